// >>> dv/adc_conv_ctl_tb.sv
// testbench for the converter control block
// assumes the core model beside it and a 25 MHz system clock
`timescale 1ns/1ps
module adc_conv_ctl_tb;
  localparam logic [3:0] A_CTRL = adc_ctl_pkg::CTRL_OFFSET;
  localparam logic [3:0] A_HI   = adc_ctl_pkg::RES_HI_OFFSET;
  localparam logic [3:0] A_LO   = adc_ctl_pkg::RES_LO_OFFSET;
  logic clk = 1'b0, rst_b = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, cmp_bit, mux_en, adcin_en;
  logic power, sample, autozero, step;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd_v;
  logic [15:0] pos_sel, neg_sel;
  logic [9:0] code = 10'h000;
  int err_count = 0, total_checks = 0, steps = 0, samps = 0, azs = 0;

  always #20 clk = ~clk;

  adc_conv_ctl uut (.CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CMP_BIT(cmp_bit), .POS_SEL(pos_sel), .NEG_SEL(neg_sel), .MUX_OUTPUT_PIN_EN(mux_en),
    .CONVERTER_INPUT_PIN_EN(adcin_en), .ADC_POWER(power), .ADC_SAMPLE(sample),
    .ADC_AUTOZERO(autozero), .ADC_STEP(step));

  adc_core_model core (.CLK(clk), .RST_B(rst_b), .power(power), .step(step), .code(code),
    .cmp_bit(cmp_bit));

  // phase counters while powered; no step pulse while powered down
  always @(posedge clk) begin
    if (rst_b && power) begin
      steps <= steps + int'(step);
      samps <= samps + int'(sample);
      azs <= azs + int'(autozero);
    end else if (rst_b && step) begin
      err_count++;
      $display("ERROR step_idle expected 0 seen 1");
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_resp(input string name, input logic [1:0] exp, input logic [1:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    if (n > 2000) begin
      err_count++;
      $display("ERROR handshake_wait expected answer seen none");
      end_sim();
    end
  endtask

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
      tick(n);
    end while (!(bvalid && bready));
    resp = bresp;
  endtask

  task automatic rd(input logic [3:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
      tick(n);
    end while (!(rvalid && rready));
    rd_v = rdata;
    resp = rresp;
  endtask

  task automatic wrc(input logic [3:0] a, input logic [7:0] d);
    wr(a, d);
    chk_resp("bresp", adc_ctl_pkg::RESP_OKAY, resp);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string name);
    rd(a);
    chk(name, {24'h00_0000, e}, rd_v);
    chk_resp("rresp", adc_ctl_pkg::RESP_OKAY, resp);
  endtask

  // poll the busy bit through the register bus
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      rd(A_CTRL);
      n++;
      tick(n * 4);
    end while (rd_v[0] !== 1'b0);
  endtask

  task automatic conv(input logic [7:0] c, input logic [9:0] v);
    int dv;
    dv = c[1] ? 16 : 1;
    code <= v;
    steps = 0;
    samps = 0;
    azs = 0;
    wrc(A_CTRL, {c[7:1], 1'b1});
    wait_done();
    chk("step_count", 32'h0000_000A, 32'(steps));
    chk("sample_cycles", 32'(3 * dv), 32'(samps));
    chk("autozero_cycles", 32'(dv), 32'(azs));
    rdc(A_HI, v[9:2], "result_high");
    rdc(A_LO, {v[1:0], 6'h00}, "result_low");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc(A_CTRL, 8'h00, "ctrl_reset");
    chk("power_reset", 32'h0000_0000, {31'h0, power});
    $display("test reset done");
    // every code 0..11 in both modes with mux output on and busy clear
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 12; c++) begin
        wrc(A_CTRL, {c[3:0], m[0], 3'b100});
        repeat (3) @(posedge clk);
        chk("pos_sel", {16'h0000, 16'h0001 << c}, {16'h0000, pos_sel});
        chk("neg_sel", {16'h0000, m ? 16'h0001 << (c ^ 1) : 16'h0000}, {16'h0000, neg_sel});
        chk("mux_pins", 32'h0000_0003, {30'h0, mux_en, adcin_en});
      end
    end
    rdc(A_CTRL, 8'hBC, "ctrl_fields");
    repeat (10) @(posedge clk);
    conv(8'hBC, 10'h1E7);
    $display("test select done");
    conv(8'h30, 10'h2A5);
    conv(8'h72, 10'h15A);
    $display("test convert done");
    wrc(A_HI, 8'h5C);
    rdc(A_HI, 8'h5C, "high_write");
    wrc(A_LO, 8'hFF);
    rdc(A_LO, 8'hC0, "low_write");
    $display("test result access done");
    code <= 10'h3FF;
    wrc(A_CTRL, 8'h53);
    wrc(A_CTRL, 8'hA9);
    rdc(A_CTRL, 8'h53, "ctrl_locked");
    wrc(A_CTRL, 8'hA8);
    repeat (3) @(posedge clk);
    chk("power_abort", 32'h0000_0000, {31'h0, power});
    rdc(A_CTRL, 8'h52, "ctrl_abort");
    rdc(A_HI, 8'h5C, "high_kept");
    rdc(A_LO, 8'hC0, "low_kept");
    wrc(A_CTRL, 8'h53);
    repeat (20) @(posedge clk);
    wrc(A_CTRL, 8'h52);
    conv(8'h52, 10'h0C3);
    $display("test abort restart done");
    wr(4'hC, 8'h01);
    chk_resp("bresp_unmapped", adc_ctl_pkg::RESP_SLVERR, resp);
    rd(4'hC);
    chk_resp("rresp_unmapped", adc_ctl_pkg::RESP_SLVERR, resp);
    chk("rdata_unmapped", 32'h0000_0000, rd_v);
    $display("test unmapped done");
    end_sim();
  end
endmodule

// >>> dv/adc_core_model.sv
// analog core model: comparator decisions for a preset ten-bit code
// assumes one-cycle step pulses, most significant bit tried first
`timescale 1ns/1ps
module adc_core_model (
  input  wire logic       CLK,
  input  wire logic       RST_B,
  input  wire logic       power,
  input  wire logic       step,
  input  wire logic [9:0] code,
  output logic            cmp_bit
);
  logic [3:0] idx_q;
  logic [3:0] idx_d;

  // bit pointer restarts whenever the converter is powered down
  always_comb begin
    idx_d = idx_q;
    if (!power) begin
      idx_d = 4'h9;
    end else if (step && idx_q != 4'h0) begin
      idx_d = idx_q - 4'h1;
    end
  end

  // pointer register
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      idx_q <= 4'h9;
    end else begin
      idx_q <= idx_d;
    end
  end

  // ideal comparator: decision for the bit under trial; at divide by 1 the
  // step of the previous trial is still in flight, so look one bit ahead
  assign cmp_bit = code[idx_d];
endmodule

// >>> hw/adc_chan_decode.sv
// channel pair decoder for the analog multiplexer
// assumes the channel code is stable while a conversion runs
`timescale 1ns/1ps
module adc_chan_decode (
  input  wire logic [3:0]  chan,
  input  wire logic        diff,
  input  wire logic        mux_out,
  input  wire logic        active,
  output logic      [15:0] pos_sel,
  output logic      [15:0] neg_sel,
  output logic             muxout_route,
  output logic             adcin_route
);
  function automatic logic [15:0] onehot(input logic [3:0] n);
    onehot = 16'h0001 << n;
  endfunction

  // positive member n, negative member n xor 1 in differential mode
  always_comb begin
    pos_sel      = 16'h0000;
    neg_sel      = 16'h0000;
    muxout_route = 1'b0;
    adcin_route  = 1'b0;
    if (active || mux_out) begin
      pos_sel = onehot(chan);
      if (diff) begin
        neg_sel = onehot(chan ^ 4'h1);
      end
      muxout_route = mux_out;
      adcin_route  = mux_out;
    end
  end
endmodule

// >>> hw/adc_conv_ctl.sv
// converter control: control register, result registers, sequencer
// assumes an AXI4-Lite master and an analog core that delivers a bit per step
//
// How it works
// - codes 0 to 11 select channel n or pair n, n xor 1 regardless of mux
// - mux output drives channel 14 pin, converter input from channel 15 pin
// - with mux output on, channel and input path stay enabled even idle
// - mode bit zero is single ended, one is differential
// - busy clear stops prescaler and converter clock
// - setting busy starts conversion with current control settings
// - normal completion clears busy and powers converter down
// - writing busy zero aborts; restart is zero then one
// - result high holds bits 9..2, result low 7..6 holds bits 1..0
// - result low bits 5..0 read zero
// - results writable, loaded at completion, held until next completion
// - result registers have no reset value
// - control: channel 7..4, mode 3, mux 2, divide 1, busy 0, reset zero
// - while busy only the busy bit of control accepts writes; result registers stay writable
// - conversion is 3 sample, 1 auto-zero, 10 convert, 1 load clocks
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module adc_conv_ctl (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic [3:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [3:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        CMP_BIT,
  output logic [15:0]      POS_SEL,
  output logic [15:0]      NEG_SEL,
  output logic             MUX_OUTPUT_PIN_EN,
  output logic             CONVERTER_INPUT_PIN_EN,
  output logic             ADC_POWER,
  output logic             ADC_SAMPLE,
  output logic             ADC_AUTOZERO,
  output logic             ADC_STEP
);
  // bus slave state
  logic        aw_have_q, aw_have_d;
  logic        w_have_q, w_have_d;
  logic [3:0]  awaddr_q, awaddr_d;
  logic [7:0]  wdata_q, wdata_d;
  logic        wstrb0_q, wstrb0_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        rvalid_q, rvalid_d;
  logic [1:0]  rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  // block state
  logic [7:0]  ctrl_q, ctrl_d;
  logic [7:0]  res_hi_q, res_hi_d;
  logic [1:0]  res_lo_q, res_lo_d;
  logic [9:0]  sar_q, sar_d;
  logic [3:0]  step_q, step_d;
  adc_ctl_pkg::conv_state_type state_q, state_d;
  // registered analog controls
  logic [15:0] pos_q, neg_q;
  logic        mo_q, ai_q, pwr_q, smp_q, az_q, stp_q;
  logic [15:0] pos_c, neg_c;
  logic        mo_c, ai_c;
  logic        tick, do_write, busy;
  logic        aw_rdy_q, w_rdy_q, ar_rdy_q;

  assign busy = ctrl_q[adc_ctl_pkg::BUSY_BIT];
  assign do_write = aw_have_q && w_have_q && !bvalid_q;

  adc_prescaler u_presc (
    .CLK   (CLK),
    .RST_B (RST_B),
    .run   (busy),
    .div16 (ctrl_q[adc_ctl_pkg::DIV_BIT]),
    .tick  (tick)
  );

  adc_chan_decode u_dec (
    .chan         (ctrl_q[adc_ctl_pkg::CHAN_MSB:adc_ctl_pkg::CHAN_LSB]),
    .diff         (ctrl_q[adc_ctl_pkg::MODE_BIT]),
    .mux_out      (ctrl_q[adc_ctl_pkg::MUXOUT_BIT]),
    .active       (busy),
    .pos_sel      (pos_c),
    .neg_sel      (neg_c),
    .muxout_route (mo_c),
    .adcin_route  (ai_c)
  );

  // write channel: capture address and data in either order, then answer
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb0_d  = wstrb0_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (S_AXI_AWVALID && !aw_have_q) begin
      aw_have_d = 1'b1;
      awaddr_d  = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_have_q) begin
      w_have_d = 1'b1;
      wdata_d  = S_AXI_WDATA[7:0];
      wstrb0_d = S_AXI_WSTRB[0];
    end
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (awaddr_q == adc_ctl_pkg::CTRL_OFFSET ||
                   awaddr_q == adc_ctl_pkg::RES_HI_OFFSET ||
                   awaddr_q == adc_ctl_pkg::RES_LO_OFFSET) ?
                  adc_ctl_pkg::RESP_OKAY : adc_ctl_pkg::RESP_SLVERR;
    end else if (bvalid_q && S_AXI_BREADY) begin
      bvalid_d = 1'b0;
    end
  end

  // read channel: one outstanding read, answered the cycle after address
  always_comb begin
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    if (S_AXI_ARVALID && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d  = adc_ctl_pkg::RESP_OKAY;
      unique case (S_AXI_ARADDR)
        adc_ctl_pkg::CTRL_OFFSET:   rdata_d = {24'h00_0000, ctrl_q};
        adc_ctl_pkg::RES_HI_OFFSET: rdata_d = {24'h00_0000, res_hi_q};
        adc_ctl_pkg::RES_LO_OFFSET: rdata_d = {24'h00_0000, res_lo_q, 6'h00};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = adc_ctl_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_d = 1'b0;
    end
  end

  // control, results and sequencer
  always_comb begin
    ctrl_d   = ctrl_q;
    res_hi_d = res_hi_q;
    res_lo_d = res_lo_q;
    sar_d    = sar_q;
    step_d   = step_q;
    state_d  = state_q;
    // sequencer advances on converter clock ticks only
    if (tick) begin
      unique case (state_q)
        adc_ctl_pkg::IDLE: begin
          state_d = adc_ctl_pkg::SAMPLE;
          step_d  = 4'h0;
        end
        adc_ctl_pkg::SAMPLE: begin
          step_d = step_q + 4'h1;
          if (step_q == adc_ctl_pkg::SAMPLE_LAST) begin
            state_d = adc_ctl_pkg::AUTOZERO;
          end
        end
        adc_ctl_pkg::AUTOZERO: begin
          state_d = adc_ctl_pkg::CONVERT;
          step_d  = 4'h0;
        end
        adc_ctl_pkg::CONVERT: begin
          sar_d  = {sar_q[8:0], CMP_BIT};
          step_d = step_q + 4'h1;
          if (step_q == adc_ctl_pkg::CONVERT_LAST) begin
            state_d = adc_ctl_pkg::LOAD;
          end
        end
        adc_ctl_pkg::LOAD: begin
          res_hi_d = sar_q[9:2];
          res_lo_d = sar_q[1:0];
          ctrl_d[adc_ctl_pkg::BUSY_BIT] = 1'b0;
          state_d  = adc_ctl_pkg::IDLE;
        end
      endcase
    end
    // software writes
    if (do_write && wstrb0_q) begin
      if (awaddr_q == adc_ctl_pkg::CTRL_OFFSET) begin
        if (busy) begin
          ctrl_d[adc_ctl_pkg::BUSY_BIT] = wdata_q[adc_ctl_pkg::BUSY_BIT];
        end else begin
          ctrl_d = wdata_q;
        end
        if (!wdata_q[adc_ctl_pkg::BUSY_BIT]) begin
          state_d = adc_ctl_pkg::IDLE;
        end
      end else if (awaddr_q == adc_ctl_pkg::RES_HI_OFFSET) begin
        res_hi_d = wdata_q;
      end else if (awaddr_q == adc_ctl_pkg::RES_LO_OFFSET) begin
        res_lo_d = wdata_q[7:6];
      end
    end
    if (!ctrl_d[adc_ctl_pkg::BUSY_BIT]) begin
      state_d = adc_ctl_pkg::IDLE;
    end
  end

  // bus and control registers, reset to known values
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 4'h0;
      wdata_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      rvalid_q  <= 1'b0;
      rresp_q   <= 2'h0;
      rdata_q   <= 32'h0000_0000;
      ctrl_q    <= adc_ctl_pkg::CTRL_RESET;
      state_q   <= adc_ctl_pkg::IDLE;
      step_q    <= 4'h0;
      sar_q     <= 10'h000;
      pos_q     <= 16'h0000;
      neg_q     <= 16'h0000;
      mo_q      <= 1'b0;
      ai_q      <= 1'b0;
      pwr_q     <= 1'b0;
      smp_q     <= 1'b0;
      az_q      <= 1'b0;
      stp_q     <= 1'b0;
      aw_rdy_q  <= 1'b1;
      w_rdy_q   <= 1'b1;
      ar_rdy_q  <= 1'b1;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb0_q  <= wstrb0_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      ctrl_q    <= ctrl_d;
      state_q   <= state_d;
      step_q    <= step_d;
      sar_q     <= sar_d;
      pos_q     <= pos_c;
      neg_q     <= neg_c;
      mo_q      <= mo_c;
      ai_q      <= ai_c;
      pwr_q     <= ctrl_d[adc_ctl_pkg::BUSY_BIT];
      smp_q     <= state_d == adc_ctl_pkg::SAMPLE;
      az_q      <= state_d == adc_ctl_pkg::AUTOZERO;
      stp_q     <= tick && state_q == adc_ctl_pkg::CONVERT;
      aw_rdy_q  <= !aw_have_d;
      w_rdy_q   <= !w_have_d;
      ar_rdy_q  <= !rvalid_d;
    end
  end

  // result registers carry no reset
  always_ff @(posedge CLK) begin
    res_hi_q <= res_hi_d;
    res_lo_q <= res_lo_d;
  end

  // port drive
  assign S_AXI_AWREADY          = aw_rdy_q;
  assign S_AXI_WREADY           = w_rdy_q;
  assign S_AXI_BVALID           = bvalid_q;
  assign S_AXI_BRESP            = bresp_q;
  assign S_AXI_ARREADY          = ar_rdy_q;
  assign S_AXI_RVALID           = rvalid_q;
  assign S_AXI_RRESP            = rresp_q;
  assign S_AXI_RDATA            = rdata_q;
  assign POS_SEL                = pos_q;
  assign NEG_SEL                = neg_q;
  assign MUX_OUTPUT_PIN_EN      = mo_q;
  assign CONVERTER_INPUT_PIN_EN = ai_q;
  assign ADC_POWER              = pwr_q;
  assign ADC_SAMPLE             = smp_q;
  assign ADC_AUTOZERO           = az_q;
  assign ADC_STEP               = stp_q;

  // locked fields do not move while busy
  chk_ctrl_locked: assert property (@(posedge CLK) disable iff (!RST_B)
    busy && $past(busy) |-> $stable(ctrl_q[7:1]))
    else $error("control field changed while busy");

  // result high takes shift register bits 9..2 as busy falls, unless a write came the cycle before
  chk_result_timing: assert property (@(posedge CLK) disable iff (!RST_B)
    $fell(busy) && !$past(do_write) |-> res_hi_q == $past(sar_q[9:2]))
    else $error("result not loaded with busy clear");

  // no converter activity once busy has been low for a cycle
  chk_power_busy: assert property (@(posedge CLK) disable iff (!RST_B)
    !busy && !$past(busy) |-> !ADC_POWER && !ADC_SAMPLE && !ADC_AUTOZERO && !ADC_STEP)
    else $error("converter active while idle");

  // a control write with busy zero stops the sequencer at once
  chk_abort_idle: assert property (@(posedge CLK) disable iff (!RST_B)
    do_write && wstrb0_q && awaddr_q == adc_ctl_pkg::CTRL_OFFSET &&
    !wdata_q[adc_ctl_pkg::BUSY_BIT] |=> !busy && state_q == adc_ctl_pkg::IDLE)
    else $error("abort did not stop the conversion");

  // load step hands both result halves over as busy clears
  chk_load_result: assert property (@(posedge CLK) disable iff (!RST_B)
    tick && state_q == adc_ctl_pkg::LOAD && !do_write |=>
    !busy && res_hi_q == $past(sar_q[9:2]) && res_lo_q == $past(sar_q[1:0]))
    else $error("result not loaded at completion");

  // mux routing follows the mux bit
  chk_mux_route: assert property (@(posedge CLK) disable iff (!RST_B)
    $past(ctrl_q[adc_ctl_pkg::MUXOUT_BIT]) |-> MUX_OUTPUT_PIN_EN && CONVERTER_INPUT_PIN_EN)
    else $error("mux output not routed");
endmodule

// >>> hw/adc_ctl_pkg.sv
// constants shared by the converter control block
// assumes a 25 MHz system clock and an AXI4-Lite register bus
package adc_ctl_pkg;
  // register byte offsets
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] RES_HI_OFFSET = 4'h4;
  localparam logic [3:0] RES_LO_OFFSET = 4'h8;
  // control field positions
  localparam int CHAN_MSB   = 7;
  localparam int CHAN_LSB   = 4;
  localparam int MODE_BIT   = 3;
  localparam int MUXOUT_BIT = 2;
  localparam int DIV_BIT    = 1;
  localparam int BUSY_BIT   = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // result low keeps only its top two bits
  localparam logic [7:0] RES_LO_MASK = 8'hC0;
  // converter clock divide and phase lengths
  localparam logic [3:0] DIV16_LAST   = 4'hF;
  localparam logic [3:0] SAMPLE_LAST  = 4'h2;
  localparam logic [3:0] CONVERT_LAST = 4'h9;
  localparam logic [3:0] CHAN_MUXOUT  = 4'hE;
  localparam logic [3:0] CHAN_ADCIN   = 4'hF;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  typedef enum logic [2:0] {IDLE, SAMPLE, AUTOZERO, CONVERT, LOAD} conv_state_type;
endpackage

// >>> hw/adc_prescaler.sv
// converter clock tick generator
// assumes run is held low whenever no conversion is active
`timescale 1ns/1ps
module adc_prescaler (
  input  wire logic CLK,
  input  wire logic RST_B,
  input  wire logic run,
  input  wire logic div16,
  output logic      tick
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  // counter frozen and cleared while idle
  always_comb begin
    cnt_d = 4'h0;
    if (run && div16) begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // divide by 1 ticks every cycle, divide by 16 once per wrap
  assign tick = run && (!div16 || cnt_q == adc_ctl_pkg::DIV16_LAST);
endmodule
